// ---- flbp_pkg.sv ----
// Purpose: shared constants and carriers for the region lock block
// Assumes: 24-bit flash address, 4KB sectors, 64KB blocks
// Notes:   edge counts are rising serial clock edges inside one frame
package flbp_pkg;
    // address geometry
    localparam int ADDR_W       = 24;
    localparam int SECT_LSB     = 12;
    localparam int BLK_LSB      = 16;
    localparam int SECT_W       = ADDR_W - SECT_LSB;
    localparam int BLK_W        = ADDR_W - BLK_LSB;
    localparam int NUM_SECT     = 1 << SECT_W;
    localparam int SECT_PER_BLK = 1 << (BLK_LSB - SECT_LSB);
    localparam logic [BLK_W:0] NUM_BLK = 9'h100;
    localparam int BP_W         = 5;

    // opcodes
    localparam logic [7:0] OP_WRITE_ENABLE_CMD    = 8'h06;
    localparam logic [7:0] OP_SLOCK   = 8'h36;
    localparam logic [7:0] OP_SUNLOCK = 8'h39;
    localparam logic [7:0] OP_QUERY   = 8'h3D;
    localparam logic [7:0] OP_GLOCK   = 8'h7E;
    localparam logic [7:0] OP_GUNLOCK = 8'h98;

    // frame lengths in edges
    localparam logic [5:0] SPI_OP_EDGES  = 6'h08;
    localparam logic [5:0] SPI_CMD_EDGES = 6'h20;
    localparam logic [5:0] SPI_STAT_LAST = 6'h27;
    localparam logic [5:0] QPI_OP_EDGES  = 6'h02;
    localparam logic [5:0] QPI_CMD_EDGES = 6'h08;
    localparam logic [5:0] QPI_STAT_LAST = 6'h09;
    localparam logic [5:0] EDGE_SAT      = 6'h3F;
    localparam logic [5:0] EDGE_ONE      = 6'h01;

    // pin lanes
    localparam int         SPI_IN_LINE  = 0;
    localparam int         SPI_OUT_LINE = 1;
    localparam logic [3:0] OE_SPI       = 4'h2;
    localparam logic [3:0] OE_QPI       = 4'hF;
    localparam logic       LOCK_RST     = 1'b1;

    // what the link side captured in the last frame
    typedef struct packed {
        logic [31:0] spi_word;
        logic [31:0] qpi_word;
        logic [5:0]  edges;
        logic        tog;
    } flbp_frame_s;

    // configuration and status levels
    typedef struct packed {
        logic            protect_scheme_select;
        logic            range_complement_bit;
        logic [BP_W-1:0] range_protect_bits;
        logic            sector_grain;
        logic            qpi_mode;
    } flbp_cfg_s;

    // program or erase permission query
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
    } flbp_pe_req_s;
endpackage

// ---- flbp_sync.sv ----
// Purpose: two flop level synchroniser
// Assumes: d is a level, not a pulse
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module flbp_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clocking
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    // level in and out
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // two stages, frozen by the enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= RST_VAL;
            q_reg    <= RST_VAL;
        end else if (en) begin
            meta_reg <= d;
            q_reg    <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule // flbp_sync

// ---- flbp_link.sv ----
// Purpose: serial clock side of the lock command port
// Assumes: host launches data so it is stable at rising edges
// Notes:   capture holds after CS rises until the next frame's first edge
`timescale 1ns/1ps
module flbp_link (
    // link pins
    input  wire logic             sclk,
    input  wire logic             cs_n,
    input  wire logic [3:0]       sio_in,
    input  wire logic             rst_n,
    // levels from the core side
    input  wire logic             qpi_mode,
    input  wire logic             stat_spi,
    input  wire logic             stat_qpi,
    // capture and pin drive
    output flbp_pkg::flbp_frame_s frame,
    output logic [3:0]            sio_out,
    output logic [3:0]            sio_oe
);
    import flbp_pkg::*;

    logic        first_reg;
    flbp_frame_s frame_reg;
    flbp_frame_s frame_next;
    logic [3:0]  out_reg;
    logic [3:0]  out_next;
    logic [3:0]  oe_reg;
    logic [3:0]  oe_next;
    logic        qpi_s;
    logic        spi_query;
    logic        qpi_query;

    // mode only matters after many edges, so two edges of lag are harmless
    flbp_sync #(.W(1), .RST_VAL(1'b0)) u_mode_sync (
        .clk   (sclk),
        .rst_n (1'b1),
        .en    (1'b1),
        .d     (qpi_mode),
        .q     (qpi_s)
    );

    // marks the first edge of a frame; set while CS is high
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    // shift both lane views; core picks one by mode
    always_comb begin
        frame_next = frame_reg;
        if (first_reg) begin
            frame_next.edges    = EDGE_ONE;
            frame_next.tog      = ~frame_reg.tog;
            frame_next.spi_word = {31'h0, sio_in[SPI_IN_LINE]};
            frame_next.qpi_word = {28'h0, sio_in};
        end else begin
            if (frame_reg.edges != EDGE_SAT) begin
                frame_next.edges = frame_reg.edges + EDGE_ONE;
            end
            if (frame_reg.edges < SPI_CMD_EDGES) begin
                frame_next.spi_word = {frame_reg.spi_word[30:0], sio_in[SPI_IN_LINE]};
            end
            if (frame_reg.edges < QPI_CMD_EDGES) begin
                frame_next.qpi_word = {frame_reg.qpi_word[27:0], sio_in};
            end
        end
    end

    // sclk is stopped while reset is low, so release is safe
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            frame_reg <= '0;
        end else begin
            frame_reg <= frame_next;
        end
    end

    assign spi_query = (frame_reg.spi_word[31:24] == OP_QUERY);
    assign qpi_query = (frame_reg.qpi_word[31:24] == OP_QUERY);

    // status byte is seven zeros then the lock bit
    always_comb begin
        out_next = 4'h0;
        oe_next  = 4'h0;
        if (qpi_s) begin
            if (qpi_query && frame_reg.edges >= QPI_CMD_EDGES && frame_reg.edges <= QPI_STAT_LAST) begin
                oe_next = OE_QPI;
                if (frame_reg.edges == QPI_STAT_LAST) begin
                    out_next = {3'h0, stat_qpi};
                end
            end
        end else if (spi_query && frame_reg.edges >= SPI_CMD_EDGES && frame_reg.edges <= SPI_STAT_LAST) begin
            oe_next = OE_SPI;
            if (frame_reg.edges == SPI_STAT_LAST) begin
                out_next[SPI_OUT_LINE] = stat_spi;
            end
        end
    end

    // launch on falling edge; CS high releases the lines at once
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            out_reg <= 4'h0;
            oe_reg  <= 4'h0;
        end else begin
            out_reg <= out_next;
            oe_reg  <= oe_next;
        end
    end

    assign frame   = frame_reg;
    assign sio_out = out_reg;
    assign sio_oe  = oe_reg;

    a_spi_status_bit: assert property (@(posedge sclk) disable iff (cs_n)
        !qpi_s && spi_query && frame_reg.edges == SPI_STAT_LAST
        |-> oe_reg == OE_SPI && out_reg[SPI_OUT_LINE] == stat_spi)
        else $error("status bit not driven on query");
    a_qpi_status_bit: assert property (@(posedge sclk) disable iff (cs_n)
        qpi_s && qpi_query && frame_reg.edges == QPI_STAT_LAST
        |-> oe_reg == OE_QPI && out_reg == {3'h0, stat_qpi})
        else $error("status nibble not driven on query");
    c_spi_query: cover property (@(posedge sclk) disable iff (cs_n)
        spi_query && frame_reg.edges == SPI_STAT_LAST);
endmodule // flbp_link

// ---- flbp_lock_ctrl.sv ----
// Purpose: volatile region lock bits and the commands that set them
// Assumes: lock bits change only after CS rises, so the link may read them
// Notes:   one bit per sector; block commands act on sixteen sectors
//          a frame cut off the byte boundary leaves the write enable latch as it was
`timescale 1ns/1ps

module flbp_lock_ctrl (
    // core clocking
    input  wire logic              CORE_CLK,
    input  wire logic              RST_N,
    input  wire logic              CE,
    // serial link
    input  wire logic              LINK_SCLK,
    input  wire logic              LINK_CS_N,
    input  wire logic [3:0]        SIO_IN,
    output logic [3:0]             SIO_OUT,
    output logic [3:0]             SIO_OE,
    // configuration
    input  flbp_pkg::flbp_cfg_s    CFG,
    // program or erase permission
    input  flbp_pkg::flbp_pe_req_s PE_REQ,
    output logic                   PE_ACK,
    output logic                   PE_DENY,
    // status
    output logic                   WEL
);
    import flbp_pkg::*;

    flbp_frame_s         frm;
    logic                cs_s;
    logic                cs_d_reg;
    logic                cs_d_next;
    logic                seen_reg;
    logic                seen_next;
    logic                wel_reg;
    logic                wel_next;
    logic [NUM_SECT-1:0] lock_reg;
    logic [NUM_SECT-1:0] lock_next;
    logic                ack_reg;
    logic                ack_next;
    logic                deny_reg;
    logic                deny_next;
    logic                stat_spi;
    logic                stat_qpi;
    logic                cs_rise;
    logic                exec;
    logic [31:0]         word;
    logic [5:0]          op_e;
    logic [5:0]          cmd_e;
    logic [5:0]          byte_mask;
    logic                aligned;
    logic                short_len;
    logic                long_len;
    logic                is_glock;
    logic                is_gunlock;
    logic                is_slock;
    logic                is_sunlock;
    logic                lock_cmd;
    logic                do_glock;
    logic                do_gunlock;
    logic                do_slock;
    logic                do_sunlock;
    logic [SECT_W-1:0]   cmd_base;
    logic                pe_prot;

    // first sector of the region an address names
    function automatic logic [SECT_W-1:0] region_base(input logic [ADDR_W-1:0] a, input logic sect);
        if (sect) begin
            region_base = a[ADDR_W-1:SECT_LSB];
        end else begin
            region_base = {a[ADDR_W-1:BLK_LSB], {(BLK_LSB-SECT_LSB){1'b0}}};
        end
    endfunction

    // a block counts as locked when any of its sectors is
    function automatic logic region_locked(input logic [NUM_SECT-1:0] arr,
                                           input logic [ADDR_W-1:0] a, input logic sect);
        logic [SECT_W-1:0] b;
        b = region_base(a, sect);
        region_locked = 1'b0;
        for (int j = 0; j < SECT_PER_BLK; j++) begin
            if (j == 0 || !sect) begin
                region_locked = region_locked | arr[b + SECT_W'(j)];
            end
        end
    endfunction

    // simplified range scheme: top 2^(n-1) blocks, complement inverts
    function automatic logic range_hit(input logic [ADDR_W-1:0] a, input logic [BP_W-1:0] bp,
                                       input logic cmp);
        logic [BLK_W:0] cnt;
        logic           hit;
        cnt = '0;
        // counts past the array size simply protect everything
        if (bp == '0) begin
            hit = 1'b0;
        end else if (bp > BP_W'(BLK_W + 1)) begin
            hit = 1'b1;
        end else begin
            cnt = (BLK_W + 1)'(1) << (bp - BP_W'(1));
            hit = ({1'b0, a[ADDR_W-1:BLK_LSB]} + cnt) >= NUM_BLK;
        end
        range_hit = hit ^ cmp;
    endfunction

    // chip select into the core domain
    flbp_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .en    (CE),
        .d     (LINK_CS_N),
        .q     (cs_s)
    );

    flbp_link u_link (
        .sclk     (LINK_SCLK),
        .cs_n     (LINK_CS_N),
        .sio_in   (SIO_IN),
        .rst_n    (RST_N),
        .qpi_mode (CFG.qpi_mode),
        .stat_spi (stat_spi),
        .stat_qpi (stat_qpi),
        .frame    (frm),
        .sio_out  (SIO_OUT),
        .sio_oe   (SIO_OE)
    );

    // query answers; lock bits stay still during any frame
    // block grain reports locked if any of its sixteen sectors is
    assign stat_spi = region_locked(lock_reg, frm.spi_word[ADDR_W-1:0], CFG.sector_grain);
    assign stat_qpi = region_locked(lock_reg, frm.qpi_word[ADDR_W-1:0], CFG.sector_grain);

    // frame decode at CS rise; capture is stable by then
    always_comb begin
        // a frame runs once: its toggle must differ from the last one seen
        cs_rise   = cs_s && !cs_d_reg;
        exec      = cs_rise && (frm.tog != seen_reg);
        word      = CFG.qpi_mode ? frm.qpi_word : frm.spi_word;
        op_e      = CFG.qpi_mode ? QPI_OP_EDGES : SPI_OP_EDGES;
        cmd_e     = CFG.qpi_mode ? QPI_CMD_EDGES : SPI_CMD_EDGES;
        byte_mask = op_e - EDGE_ONE;
        // byte boundary: edge count is a whole number of opcode phases
        aligned   = ((frm.edges & byte_mask) == '0) && (frm.edges != EDGE_SAT);
        short_len = aligned && (frm.edges == op_e);
        long_len  = aligned && (frm.edges == cmd_e);
        is_glock   = exec && short_len && (word[7:0] == OP_GLOCK);
        is_gunlock = exec && short_len && (word[7:0] == OP_GUNLOCK);
        is_slock   = exec && long_len && (word[31:24] == OP_SLOCK);
        is_sunlock = exec && long_len && (word[31:24] == OP_SUNLOCK);
        lock_cmd   = is_glock || is_gunlock || is_slock || is_sunlock;
        // write enable gates every lock type command
        do_glock   = is_glock && wel_reg;
        do_gunlock = is_gunlock && wel_reg;
        do_slock   = is_slock && wel_reg;
        do_sunlock = is_sunlock && wel_reg;
        cmd_base   = region_base(word[ADDR_W-1:0], CFG.sector_grain);
    end

    // lock bits, write enable latch and frame bookkeeping
    always_comb begin
        cs_d_next = cs_s;
        seen_next = seen_reg;
        wel_next  = wel_reg;
        lock_next = lock_reg;
        if (exec) begin
            seen_next = frm.tog;
            if (short_len && word[7:0] == OP_WRITE_ENABLE_CMD) begin
                wel_next = 1'b1;
            end
            // a lock type command spends the latch even when refused
            if (lock_cmd) begin
                wel_next = 1'b0;
            end
            if (do_glock) begin
                lock_next = '1;
            end
            if (do_gunlock) begin
                lock_next = '0;
            end
            if (do_slock || do_sunlock) begin
                for (int j = 0; j < SECT_PER_BLK; j++) begin
                    if (j == 0 || !CFG.sector_grain) begin
                        lock_next[cmd_base + SECT_W'(j)] = do_slock;
                    end
                end
            end
        end
    end

    // all regions come out of reset protected
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            cs_d_reg <= 1'b1;
            seen_reg <= 1'b0;
            wel_reg  <= 1'b0;
            lock_reg <= {NUM_SECT{LOCK_RST}};
        end else if (CE) begin
            cs_d_reg <= cs_d_next;
            seen_reg <= seen_next;
            wel_reg  <= wel_next;
            lock_reg <= lock_next;
        end
    end

    // permission check; reads are never refused
    always_comb begin
        if (CFG.protect_scheme_select) begin
            pe_prot = region_locked(lock_reg, PE_REQ.addr, 1'b1);
        end else begin
            pe_prot = range_hit(PE_REQ.addr, CFG.range_protect_bits, CFG.range_complement_bit);
        end
        ack_next  = PE_REQ.valid;
        deny_next = PE_REQ.valid && PE_REQ.write && pe_prot;
    end

    // answer one cycle after the request
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ack_reg  <= 1'b0;
            deny_reg <= 1'b0;
        end else if (CE) begin
            ack_reg  <= ack_next;
            deny_reg <= deny_next;
        end
    end

    assign PE_ACK  = ack_reg;
    assign PE_DENY = deny_reg;
    assign WEL     = wel_reg;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    // lock array after reset and after each executed command
    a_reset_all_locked: assert property ($rose(RST_N) |-> &lock_reg)
        else $error("lock bits not all set after reset");
    a_global_lock_all: assert property (CE && do_glock |=> &lock_reg)
        else $error("global lock left a region open");
    a_global_unlock_all: assert property (CE && do_gunlock |=> lock_reg == '0)
        else $error("global unlock left a region locked");
    a_single_lock_bit: assert property (CE && do_slock |=> lock_reg[$past(cmd_base)])
        else $error("single lock did not set region");
    a_single_unlock_bit: assert property (CE && do_sunlock |=> !lock_reg[$past(cmd_base)])
        else $error("single unlock did not clear region");
    a_no_wel_hold: assert property (CE && lock_cmd && !wel_reg |=> $stable(lock_reg) && !wel_reg)
        else $error("lock changed without write enable");
    a_misalign_hold: assert property (CE && exec && !aligned |=> $stable(lock_reg) && $stable(wel_reg))
        else $error("misaligned frame changed locks");
    a_read_allowed: assert property (CE && PE_REQ.valid && !PE_REQ.write |=> PE_ACK && !PE_DENY)
        else $error("read was refused");
    a_locked_write_deny: assert property (CE && PE_REQ.valid && PE_REQ.write && CFG.protect_scheme_select
        && lock_reg[PE_REQ.addr[ADDR_W-1:SECT_LSB]] |=> PE_DENY)
        else $error("write to locked sector allowed");
    a_range_mode_open: assert property (CE && PE_REQ.valid && !CFG.protect_scheme_select
        && !range_hit(PE_REQ.addr, CFG.range_protect_bits, CFG.range_complement_bit) |=> !PE_DENY)
        else $error("range scheme denied an open address");

    // write enable latch bookkeeping
    a_write_enable_cmd_sets_wel: assert property (CE && exec && short_len && word[7:0] == OP_WRITE_ENABLE_CMD |=> wel_reg)
        else $error("write enable opcode did not set the latch");
    a_lock_clears_wel: assert property (CE && lock_cmd |=> !wel_reg)
        else $error("lock command left the write enable latch set");
    a_wel_only_by_write_enable_cmd: assert property (CE && !(exec && short_len && word[7:0] == OP_WRITE_ENABLE_CMD) |=> !$rose(wel_reg))
        else $error("write enable latch set without its opcode");

    // permission answers in both schemes
    a_ack_follows_req: assert property (CE && PE_REQ.valid |=> PE_ACK)
        else $error("permission request not acknowledged");
    a_open_write_ok: assert property (CE && PE_REQ.valid && PE_REQ.write && CFG.protect_scheme_select
        && !lock_reg[PE_REQ.addr[ADDR_W-1:SECT_LSB]] |=> !PE_DENY)
        else $error("write to unlocked sector refused");
    a_range_mode_deny: assert property (CE && PE_REQ.valid && PE_REQ.write && !CFG.protect_scheme_select
        && range_hit(PE_REQ.addr, CFG.range_protect_bits, CFG.range_complement_bit) |=> PE_DENY)
        else $error("range scheme allowed a protected write");

    // nothing else moves the lock bits; clock enable low freezes the core
    a_only_cmds_lock: assert property (CE && !(do_glock || do_gunlock || do_slock || do_sunlock) |=> $stable(lock_reg))
        else $error("lock bits changed without a command");
    a_frozen_state: assert property (!CE |=> $stable(lock_reg) && $stable(wel_reg) && $stable(PE_ACK))
        else $error("state moved while clock enable was low");

    // main scenarios
    c_global_unlock: cover property (CE && do_gunlock);
    c_single_lock: cover property (CE && do_slock);
    c_write_denied: cover property (PE_ACK && PE_DENY);
    c_rejected_lock: cover property (CE && lock_cmd && !wel_reg);
endmodule // flbp_lock_ctrl

// ---- flbp_host_model.sv ----
// Purpose: host controller model that frames lock commands on the serial link
// Assumes: mode 0 clock, idle low, running only inside a frame
// Notes:   released or unused lines toggle so a stale level never looks valid
`timescale 1ns/1ps
module flbp_host_model (
    // link pins
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      drv,
    // resolved wire levels
    input  wire logic [3:0] serial_io_lines
);
    // idle link: clock still, chip select high
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        drv  = 4'h5;
    end

    // one frame: n edges of command, then rd_n edges of read-out
    task automatic xfer(input logic [31:0] w, input int n, input logic qpi, input int rd_n,
                        output logic [7:0] rd);
        rd = 8'h00;
        #3.3;
        cs_n = 1'b0; // frame opens
        for (int i = 0; i < n + rd_n; i++) begin
            if (i >= n)
                drv = ~drv; // host has let go of the lines
            else if (qpi)
                drv = w[31-4*i -: 4]; // high nibble first
            else
                drv = {~drv[3:1], w[31-i]}; // msb first on line 0, junk above
            #6 sclk = 1'b1;
            if (i >= n)
                rd = qpi ? {rd[3:0], serial_io_lines} : {rd[6:0], serial_io_lines[1]}; // status in first byte
            #6 sclk = 1'b0;
        end
        #6 cs_n = 1'b1; // raised after the last falling edge
        drv = ~drv;
        #60; // gap above 40 ns lets the core act first
    endtask
endmodule // flbp_host_model

// ---- flash_block_lock_protection_tb.sv ----
// Purpose: self-checking bench for the region lock block
// Assumes: host model drives the link, bench drives config and permission port
// Notes:   lock state mirrored per sector; random traffic from a fixed seed
`timescale 1ns/1ps
module flash_block_lock_protection_tb;
    import flbp_pkg::*;
    logic         core_clk;
    logic         rst_n;
    logic         ce;
    logic         sclk;
    logic         cs_n;
    logic [3:0]   drv;
    logic [3:0]   sio_w;
    logic [3:0]   sio_out;
    logic [3:0]   sio_oe;
    flbp_cfg_s    cfg;
    flbp_pe_req_s pe_req;
    logic         pe_ack;
    logic         pe_deny;
    logic         wel;
    logic [4095:0] lk;
    logic [23:0]  a;
    logic [7:0]   op;
    int           seed = 18772;
    int           bad_count = 0;
    int           num_checks = 0;
    int           bps[4] = '{0, 1, 9, 10};

    // wire level: whoever enables wins, the host otherwise
    assign sio_w = (sio_oe & sio_out) | (~sio_oe & drv);

    flbp_lock_ctrl i_flbp_lock_ctrl (.CORE_CLK(core_clk), .RST_N(rst_n), .CE(ce), .LINK_SCLK(sclk),
        .LINK_CS_N(cs_n), .SIO_IN(sio_w), .SIO_OUT(sio_out), .SIO_OE(sio_oe), .CFG(cfg),
        .PE_REQ(pe_req), .PE_ACK(pe_ack), .PE_DENY(pe_deny), .WEL(wel));
    flbp_host_model i_flbp_host_model (.sclk(sclk), .cs_n(cs_n), .drv(drv), .serial_io_lines(sio_w));

    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // hang guard counts as a mismatch
    initial begin
        #200us;
        bad_count++;
        summarize();
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask

    // edge counts: opcode alone or opcode plus three address bytes
    function automatic int ln(input bit full);
        return cfg.qpi_mode ? (full ? 8 : 2) : (full ? 32 : 8);
    endfunction

    // expected query bit: a block reads locked if any sector is
    function automatic logic explk(input logic [23:0] x);
        return cfg.sector_grain ? lk[x[23:12]] : |lk[{x[23:16], 4'h0} +: 16];
    endfunction

    // simplified range scheme, complement inverts the protected set
    function automatic logic rng(input logic [23:0] x);
        int  n;
        logic p;
        n = cfg.range_protect_bits;
        p = (n == 0) ? 1'b0 : (n > 9) ? 1'b1 : (int'(x[23:16]) >= 256 - (1 << (n - 1)));
        return p ^ cfg.range_complement_bit;
    endfunction

    task automatic cmd(input logic [7:0] o, input logic [23:0] x, input int n);
        logic [7:0] rd;
        i_flbp_host_model.xfer({o, x}, n, cfg.qpi_mode, 0, rd);
    endtask

    task automatic query(input logic [23:0] x);
        logic [7:0] rd;
        i_flbp_host_model.xfer({OP_QUERY, x}, ln(1), cfg.qpi_mode, cfg.qpi_mode ? 2 : 8, rd);
        chk(rd, {7'h00, explk(x)});
    endtask

    // one permission request, answer one cycle later
    task automatic pe(input logic [23:0] x, input logic wr, input logic exp);
        @(posedge core_clk) #1;
        pe_req = '{1'b1, wr, x};
        @(posedge core_clk) #1;
        pe_req.valid = 1'b0;
        chk({7'h00, pe_ack}, 8'h01);
        chk({7'h00, pe_deny}, {7'h00, exp});
    endtask

    initial begin
        ce = 1'b1;
        rst_n = 1'b1;
        pe_req = '0;
        cfg = '0;
        cfg.protect_scheme_select = 1'b1;
        lk = '1;
        // a real falling edge, so the link's async clear is never missed at time zero
        #1 rst_n = 1'b0;
        repeat (6) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        chk({7'h00, wel}, 8'h00);
        a = $random(seed);
        query(a);
        pe(a, 1'b1, 1'b1);
        pe(a, 1'b0, 1'b0);
        // clock enable low: a request is not taken
        @(posedge core_clk) #1 ce = 1'b0;
        pe_req = '{1'b1, 1'b1, a};
        @(posedge core_clk) #1 pe_req.valid = 1'b0;
        chk({7'h00, pe_ack}, 8'h00);
        ce = 1'b1;
        // unlock without write enable changes nothing
        cmd(OP_SUNLOCK, a, 32);
        query(a);
        chk({7'h00, wel}, 8'h00);
        // whole array unlock in single-line mode with junk on upper lines
        cmd(OP_WRITE_ENABLE_CMD, 24'h0, 8);
        chk({7'h00, wel}, 8'h01);
        cmd(OP_GUNLOCK, 24'h0, 8);
        lk = '0;
        chk({7'h00, wel}, 8'h00);
        query(a);
        // random region commands in both modes and both grains
        for (int k = 0; k < 16; k++) begin
            @(posedge core_clk) #1;
            cfg.qpi_mode = $random(seed);
            cfg.sector_grain = $random(seed);
            a = $random(seed);
            op = ($random(seed) & 1) ? OP_SLOCK : OP_SUNLOCK;
            cmd(OP_WRITE_ENABLE_CMD, 24'h0, ln(0));
            cmd(op, a, ln(1));
            if (cfg.sector_grain)
                lk[a[23:12]] = (op == OP_SLOCK);
            else
                lk[{a[23:16], 4'h0} +: 16] = {16{op == OP_SLOCK}};
            chk({7'h00, wel}, 8'h00);
            query(a);
            query(a ^ 24'h001000);
            pe(a, 1'b1, lk[a[23:12]]);
        end
        // frames ending off the byte boundary are refused, write enable kept
        @(posedge core_clk) #1 cfg.qpi_mode = 1'b0;
        cmd(OP_WRITE_ENABLE_CMD, 24'h0, 8);
        cmd(op == OP_SLOCK ? OP_SUNLOCK : OP_SLOCK, a, 31);
        cmd(OP_GLOCK, 24'h0, 7);
        @(posedge core_clk) #1 cfg.qpi_mode = 1'b1;
        cmd(OP_GUNLOCK, 24'h0, 1);
        chk({7'h00, wel}, 8'h01);
        query(a);
        // whole array lock in four-line mode
        cmd(OP_WRITE_ENABLE_CMD, 24'h0, 2);
        cmd(OP_GLOCK, 24'h0, 2);
        lk = '1;
        chk({7'h00, wel}, 8'h00);
        query(a ^ 24'h5A5000);
        // four-line whole array unlock, then a mid-run reset relocks everything
        cmd(OP_WRITE_ENABLE_CMD, 24'h0, 2);
        cmd(OP_GUNLOCK, 24'h0, 2);
        lk = '0;
        query(a);
        cmd(OP_WRITE_ENABLE_CMD, 24'h0, 2);
        @(posedge core_clk) #1 rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1'b1;
        lk = '1;
        repeat (4) @(posedge core_clk);
        chk({7'h00, wel}, 8'h00);
        query(a);
        // range scheme ignores the lock bits
        cfg.protect_scheme_select = 1'b0;
        for (int k = 0; k < 8; k++) begin
            @(posedge core_clk) #1;
            cfg.range_protect_bits = bps[k % 4];
            cfg.range_complement_bit = k / 4;
            pe(24'hFF0000, 1'b1, rng(24'hFF0000));
            pe(24'h7F1000, 1'b1, rng(24'h7F1000));
        end
        summarize();
    end
endmodule // flash_block_lock_protection_tb
